// ---- logic/vpo_pkg.sv ----
/*
  Shared constants and carriers for the video pixel output port.
  Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
*/
package vpo_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LLC_PERIOD_NS = 40;
  localparam int unsigned LLC_DIV = LLC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LLC_CNT_W = $clog2(LLC_DIV);
  localparam logic [9:0] FRAME_SYNC_LINES = 10'h006;
  localparam int unsigned GL_BITS = 24;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  localparam logic [5:0] FIFO_HALF = 6'h10;

  // ****************************************************
  // output mode select encodings
  // ****************************************************
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_QUAL = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;

  // ****************************************************
  // register map: offsets, indices, fields
  // ****************************************************
  localparam int unsigned REG_COUNT = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HSYNC = 8'h04;
  localparam logic [7:0] OFS_HACT = 8'h08;
  localparam logic [7:0] OFS_VACT = 8'h0C;
  localparam logic [7:0] OFS_FIFO = 8'h10;
  localparam logic [7:0] OFS_GPO = 8'h14;
  localparam logic [7:0] OFS_TIMING = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [2:0] IDX_CTRL = OFS_CTRL[4:2];
  localparam logic [2:0] IDX_HSYNC = OFS_HSYNC[4:2];
  localparam logic [2:0] IDX_HACT = OFS_HACT[4:2];
  localparam logic [2:0] IDX_VACT = OFS_VACT[4:2];
  localparam logic [2:0] IDX_FIFO = OFS_FIFO[4:2];
  localparam logic [2:0] IDX_GPO = OFS_GPO[4:2];
  localparam logic [2:0] IDX_TIMING = OFS_TIMING[4:2];
  localparam logic [2:0] IDX_STATUS = OFS_STATUS[4:2];

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FSPOL = 2;
  localparam int unsigned CTRL_LSPOL = 3;
  localparam int unsigned CTRL_FFPOL = 4;
  localparam int unsigned CTRL_QPOL = 5;
  localparam int unsigned CTRL_WIDE = 6;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned ST_FSYNC = 16;
  localparam int unsigned ST_VACT = 17;
  localparam int unsigned ST_HACT = 18;
  localparam int unsigned ST_NFULL = 19;
  localparam int unsigned ST_NEMPTY = 20;

  // ****************************************************
  // reset values and writable masks, by index
  // ****************************************************
  localparam logic [31:0] RST_VAL [REG_COUNT] = '{
    32'h0000_0000, 32'h0020_0000, 32'h034A_007A, 32'h0106_0016,
    32'h0000_0004, 32'h0000_0000, 32'h0106_035A, 32'h0000_0000};
  localparam logic [31:0] RW_MASK [REG_COUNT] = '{
    32'h0000_007F, 32'h03FF_03FF, 32'h03FF_03FF, 32'h03FF_03FF,
    32'h0000_001F, 32'h0000_000F, 32'h03FF_03FF, 32'h0000_0000};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } vpo_pixel_t;

endpackage

// ---- logic/vpo_sync2.sv ----
/*
  Two-stage level synchroniser.
  Assumes the input is asynchronous to i_clock; nothing reads stage one.
*/
`timescale 1ns/1ps
module vpo_sync2
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // levels
  input wire logic i_async,
  output logic o_sync
);

  logic stage1_q;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      stage1_q <= 1'b0;
      o_sync <= 1'b0;
    end
    else if (i_clk_en)
    begin
      stage1_q <= i_async;
      o_sync <= stage1_q;
    end
  end

endmodule

// ---- logic/vpo_top.sv ----
/*
  Video pixel output port: register slave, video timing, pin drivers.
  Assumes pixel data, FIFO level and genlock word come on i_clock;
  the FIFO read clock is an external pin and is synchronised here.
*/
// What this block does
// - mode 00 vertical pin is frame sync; 10 or 01 is active window
// - frame sync stays active for exactly six lines
// - vertical active window covers the viewable lines of each field
// - one polarity bit inverts both vertical pin functions
// - mode 00 line sync edges set by begin/end in steps of two
// - modes 10/01 horizontal pin shows the programmable active line part
// - one polarity bit inverts both horizontal pin functions
// - 8-bit mode muxes on upper byte; 16-bit splits luma and chroma
// - near-full flag rises when fill reaches depth minus margin
// - near-empty flag rises when fill falls to the margin
// - multifunction pin: half flag, qualified clock or genlock per mode
// - one polarity bit inverts all three FIFO flags
// - genlock pin shifts out the subcarrier lock word serially
// - FIFO modes launch outputs on the external read clock
// - four general outputs follow register writes
// - qualifier marks the half rate, with its own polarity bit
// - half-rate clock is the internal line-locked tick divided by two, even in FIFO modes
// - line-locked pin is the divided clock or the FIFO output clock
`timescale 1ns/1ps
module vpo_top
  import vpo_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // axi4-lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // decoder side
  input wire vpo_pixel_t i_pixel,
  input wire logic [5:0] i_fifo_level,
  input wire logic [GL_BITS-1:0] i_genlock_word,
  // external pins
  input wire logic i_fifo_read_clock,
  output logic [15:0] o_pixel_bus,
  output logic o_vertical_pin,
  output logic o_horizontal_pin,
  output logic o_fifo_near_full_flag,
  output logic o_fifo_near_empty_flag,
  output logic o_multi_pin,
  output logic o_line_locked_clock,
  output logic o_half_line_locked_clock,
  output logic o_pixel_clock_qualifier,
  output logic [3:0] o_general_outputs
);

  // ****************************************************
  // register file and axi4-lite slave
  // ****************************************************
  logic [31:0] regs_q [REG_COUNT];
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [31:0] strb_mask;
  logic [31:0] status;

  assign do_write = aw_full_q && w_full_q && !o_bvalid;
  assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // address and data may arrive in either order; both park until used
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (i_clk_en)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_full_q <= 1'b1;
        o_awready <= 1'b0;
        waddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_full_q <= 1'b1;
        o_wready <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (waddr_q[7:5] == 3'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // status has a zero mask, so its stored word never changes
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= RST_VAL[i];
    end
    else if (i_clk_en && do_write && waddr_q[7:5] == 3'h0)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        if (waddr_q[4:2] == 3'(i))
          regs_q[i] <= (regs_q[i] & ~(strb_mask & RW_MASK[i]))
                     | (wdata_q & strb_mask & RW_MASK[i]);
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        if (i_araddr[7:5] != 3'h0)
        begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
        else
        begin
          o_rdata <= (i_araddr[4:2] == IDX_STATUS) ? status
                   : regs_q[i_araddr[4:2]];
          o_rresp <= RESP_OKAY;
        end
      end
      if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ****************************************************
  // configuration fields
  // ****************************************************
  logic [1:0] raw_mode;
  logic [1:0] mode;
  logic fs_pol;
  logic ls_pol;
  logic ff_pol;
  logic q_pol;
  logic wide;
  logic [9:0] line_sync_begin;
  logic [9:0] line_sync_end;
  logic [9:0] ha_start;
  logic [9:0] ha_end;
  logic [9:0] va_start;
  logic [9:0] va_end;
  logic [4:0] margin;
  logic [9:0] line_len;
  logic [9:0] field_lines;

  assign raw_mode = regs_q[IDX_CTRL][CTRL_MODE_LSB +: 2];
  assign mode = (raw_mode == MODE_BAD) ? MODE_SYNC : raw_mode;
  assign fs_pol = regs_q[IDX_CTRL][CTRL_FSPOL];
  assign ls_pol = regs_q[IDX_CTRL][CTRL_LSPOL];
  assign ff_pol = regs_q[IDX_CTRL][CTRL_FFPOL];
  assign q_pol = regs_q[IDX_CTRL][CTRL_QPOL];
  assign wide = regs_q[IDX_CTRL][CTRL_WIDE];
  assign line_sync_begin = regs_q[IDX_HSYNC][LO_LSB +: 10];
  assign line_sync_end = regs_q[IDX_HSYNC][HI_LSB +: 10];
  assign ha_start = regs_q[IDX_HACT][LO_LSB +: 10];
  assign ha_end = regs_q[IDX_HACT][HI_LSB +: 10];
  assign va_start = regs_q[IDX_VACT][LO_LSB +: 10];
  assign va_end = regs_q[IDX_VACT][HI_LSB +: 10];
  assign margin = regs_q[IDX_FIFO][4:0];
  assign line_len = regs_q[IDX_TIMING][LO_LSB +: 10];
  assign field_lines = regs_q[IDX_TIMING][HI_LSB +: 10];

  // ****************************************************
  // clocks: line-locked divider and read clock edge
  // ****************************************************
  logic [LLC_CNT_W-1:0] llc_cnt_q;
  logic llc_tick;
  logic half_q;
  logic rclk_s;
  logic rclk_d_q;
  logic rclk_rise;
  logic launch;

  vpo_sync2 u_rclk_sync
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_fifo_read_clock),
    .o_sync(rclk_s)
  );

  assign llc_tick = (llc_cnt_q == LLC_CNT_W'(LLC_DIV - 1));
  assign rclk_rise = rclk_s && !rclk_d_q;
  // launch on read clock in fifo modes
  assign launch = (mode == MODE_SYNC) ? llc_tick : rclk_rise;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      llc_cnt_q <= '0;
      half_q <= 1'b0;
      rclk_d_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      llc_cnt_q <= llc_tick ? '0 : llc_cnt_q + 1'b1;
      rclk_d_q <= rclk_s;
      if (llc_tick)
        half_q <= !half_q;
    end
  end

  // divided clock or fifo output clock
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_line_locked_clock <= 1'b0;
      o_half_line_locked_clock <= 1'b0;
      o_pixel_clock_qualifier <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_line_locked_clock <= (mode == MODE_SYNC)
        ? (llc_cnt_q >= LLC_CNT_W'(LLC_DIV / 2)) : rclk_s;
      o_half_line_locked_clock <= half_q;
      o_pixel_clock_qualifier <= half_q ^ q_pol;
    end
  end

  // ****************************************************
  // video timing
  // ****************************************************
  logic [10:0] hcnt_q;
  logic [9:0] vcnt_q;
  logic vs_int;
  logic va_int;
  logic hs_int;
  logic ha_int;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      hcnt_q <= 11'h000;
      vcnt_q <= 10'h000;
    end
    else if (i_clk_en && llc_tick)
    begin
      if (hcnt_q >= {1'b0, line_len} - 11'h001)
      begin
        hcnt_q <= 11'h000;
        vcnt_q <= (vcnt_q >= field_lines - 10'h001) ? 10'h000
                : vcnt_q + 10'h001;
      end
      else
        hcnt_q <= hcnt_q + 11'h001;
    end
  end

  assign vs_int = vcnt_q < FRAME_SYNC_LINES;
  assign va_int = (vcnt_q >= va_start) && (vcnt_q < va_end);
  // edges in steps of two line-locked periods
  assign hs_int = (hcnt_q >= {line_sync_begin, 1'b0}) && (hcnt_q < {line_sync_end, 1'b0});
  assign ha_int = (hcnt_q >= {1'b0, ha_start})
               && (hcnt_q < {1'b0, ha_end});

  // ****************************************************
  // launched pins: sync, pixel bus, genlock
  // ****************************************************
  logic phase_q;
  logic [GL_BITS-1:0] gl_sh_q;
  logic [4:0] gl_cnt_q;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_vertical_pin <= 1'b0;
      o_horizontal_pin <= 1'b0;
      o_pixel_bus <= 16'h0000;
      phase_q <= 1'b0;
    end
    else if (i_clk_en && launch)
    begin
      o_vertical_pin <= ((mode == MODE_SYNC) ? vs_int : va_int) ^ fs_pol;
      o_horizontal_pin <= ((mode == MODE_SYNC) ? hs_int : ha_int) ^ ls_pol;
      phase_q <= !phase_q;
      // chroma first, then luma, in 8-bit mode
      if (wide)
        o_pixel_bus <= {i_pixel.luma, i_pixel.chroma};
      else
        o_pixel_bus <= {phase_q ? i_pixel.luma : i_pixel.chroma, 8'h00};
    end
  end

  // serial genlock word, one bit per line-locked period
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      gl_sh_q <= '0;
      gl_cnt_q <= 5'h00;
    end
    else if (i_clk_en && llc_tick)
    begin
      if (gl_cnt_q == 5'(GL_BITS - 1))
      begin
        gl_cnt_q <= 5'h00;
        gl_sh_q <= i_genlock_word;
      end
      else
      begin
        gl_cnt_q <= gl_cnt_q + 5'h01;
        gl_sh_q <= {gl_sh_q[GL_BITS-2:0], 1'b0};
      end
    end
  end

  // ****************************************************
  // fifo flags, multifunction pin, general outputs
  // ****************************************************
  logic nfull_int;
  logic nempty_int;
  logic half_int;

  // near full at depth minus margin
  assign nfull_int = i_fifo_level >= (FIFO_DEPTH - {1'b0, margin});
  assign nempty_int = i_fifo_level <= {1'b0, margin};
  assign half_int = i_fifo_level >= FIFO_HALF;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_fifo_near_full_flag <= 1'b0;
      o_fifo_near_empty_flag <= 1'b0;
      o_multi_pin <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_fifo_near_full_flag <= nfull_int ^ ff_pol;
      o_fifo_near_empty_flag <= nempty_int ^ ff_pol;
      case (mode)
        MODE_HALF: o_multi_pin <= half_int ^ ff_pol;
        MODE_QUAL: o_multi_pin <= rclk_s && ha_int && va_int;
        default: o_multi_pin <= gl_sh_q[GL_BITS-1];
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_general_outputs <= 4'h0;
    else if (i_clk_en)
      o_general_outputs <= regs_q[IDX_GPO][3:0];
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[9:0] = vcnt_q;
    status[ST_FSYNC] = vs_int;
    status[ST_VACT] = va_int;
    status[ST_HACT] = ha_int;
    status[ST_NFULL] = nfull_int;
    status[ST_NEMPTY] = nempty_int;
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_sync_launch;
    i_clk_en && launch && mode == MODE_SYNC;
  endsequence

  a_vert_mode_sel: assert property (
    i_clk_en && launch |=> o_vertical_pin ==
      ($past(mode == MODE_SYNC ? vs_int : va_int) ^ $past(fs_pol)))
    else $error("vertical pin function wrong");

  a_frame_sync_len: assert property (
    $fell(vs_int) && field_lines > FRAME_SYNC_LINES
      |-> vcnt_q == FRAME_SYNC_LINES)
    else $error("frame sync not six lines");

  // a begin/end write mid-line moves the edge to wherever the counter is
  a_line_sync_edge: assert property (
    $rose(hs_int) && !$past(i_rst) && $stable({line_sync_begin, line_sync_end})
      |-> hcnt_q == {line_sync_begin, 1'b0})
    else $error("line sync rose at wrong count");

  a_horiz_active: assert property (
    i_clk_en && launch && mode != MODE_SYNC
      |=> o_horizontal_pin == ($past(ha_int) ^ $past(ls_pol)))
    else $error("line active window wrong");

  a_near_full_flag: assert property (
    i_clk_en |=> o_fifo_near_full_flag ==
      (($past(i_fifo_level) >= FIFO_DEPTH - {1'b0, $past(margin)})
        ^ $past(ff_pol)))
    else $error("near full flag wrong");

  a_gpo_follow: assert property (
    i_clk_en && do_write && waddr_q == OFS_GPO && wstrb_q[0]
      ##1 i_clk_en |=> o_general_outputs == $past(wdata_q[3:0], 2))
    else $error("general outputs did not follow write");

  a_half_clock: assert property (
    s_sync_launch ##1 i_clk_en |=> o_half_line_locked_clock
      != $past(o_half_line_locked_clock))
    else $error("half clock did not toggle");

  a_bad_mode: assert property (
    raw_mode == MODE_BAD |-> mode == MODE_SYNC && launch == llc_tick)
    else $error("mode 11 not treated as 00");

  a_qual_pol: assert property (
    i_clk_en |=> o_pixel_clock_qualifier == ($past(half_q) ^ $past(q_pol)))
    else $error("qualifier polarity wrong");

endmodule

// ---- test/vpo_far_end.sv ----
/*
  Far-end model: downstream capture logic that supplies the FIFO read
  clock. Assumes the bench tells it when a FIFO mode is selected.
*/
`timescale 1ns/1ps
module vpo_far_end
(
  // control from the bench
  input wire logic i_run,
  // clock handed to the port
  output logic o_fifo_read_clock
);
  // ****************************************************
  // read clock
  // ****************************************************
  // read clock supplied
  // a 40 ns period keeps launch spacing equal to the internal line tick
  // the clock stands still low outside the FIFO modes
  initial
  begin
    o_fifo_read_clock = 1'b0;
    #3;
    forever
    begin
      #20;
      o_fifo_read_clock = i_run ? ~o_fifo_read_clock : 1'b0;
    end
  end
endmodule

// ---- test/video_pixel_output_port_tb.sv ----
/*
  Self-checking bench for the video pixel output port.
  Assumes the far-end model supplies the FIFO read clock in FIFO modes.
*/
`timescale 1ns/1ps
module video_pixel_output_port_tb;
  import vpo_pkg::*;
  logic i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, r;
  logic [31:0] o_rdata, i_wdata, d, seed;
  logic [31:0] model [REG_COUNT];
  logic [7:0] i_awaddr, i_araddr;
  vpo_pixel_t i_pixel;
  logic [5:0] i_fifo_level;
  logic [GL_BITS-1:0] i_genlock_word;
  logic i_fifo_read_clock, run_far, a, b;
  logic [15:0] o_pixel_bus;
  logic o_vertical_pin, o_horizontal_pin, o_multi_pin;
  logic o_fifo_near_full_flag, o_fifo_near_empty_flag;
  logic o_line_locked_clock, o_half_line_locked_clock;
  logic o_pixel_clock_qualifier;
  logic [3:0] o_general_outputs;
  int miscompares, total_checks, cycles, i, j, n, m, p, md, lv;

  vpo_top DUT (.i_clock, .i_rst, .i_clk_en(1'b1), .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_pixel, .i_fifo_level,
    .i_genlock_word, .i_fifo_read_clock, .o_pixel_bus, .o_vertical_pin,
    .o_horizontal_pin, .o_fifo_near_full_flag, .o_fifo_near_empty_flag,
    .o_multi_pin, .o_line_locked_clock, .o_half_line_locked_clock,
    .o_pixel_clock_qualifier, .o_general_outputs);
  vpo_far_end far (.i_run(run_far), .o_fifo_read_clock(i_fifo_read_clock));

  // ****************************************************
  // clock, watchdog, helpers
  // ****************************************************
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************
  // register bus master
  // ****************************************************
  // handshakes are judged on settled values just before the taking edge
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v,
    output logic [1:0] rs);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge i_clock);
    i_awaddr <= ad;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!hb)
    begin
      @(negedge i_clock);
      ha = i_awvalid & o_awready;
      hw = i_wvalid & o_wready;
      hb = o_bvalid;
      rs = o_bresp;
      @(posedge i_clock);
      if (ha)
        i_awvalid <= 1'b0;
      if (hw)
        i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] v,
    output logic [1:0] rs);
    logic ha, hr;
    hr = 1'b0;
    @(posedge i_clock);
    i_araddr <= ad;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!hr)
    begin
      @(negedge i_clock);
      ha = i_arvalid & o_arready;
      hr = o_rvalid;
      v = o_rdata;
      rs = o_rresp;
      @(posedge i_clock);
      if (ha)
        i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
  endtask

  task automatic wr(input int x, input logic [31:0] v);
    logic [1:0] rs;
    axi_wr(8'(x * 4), v, rs);
    check("write response", 32'(rs), 32'(RESP_OKAY));
    model[x] = (model[x] & ~RW_MASK[x]) | (v & RW_MASK[x]);
  endtask

  // span in clocks of one full active pulse of a timing pin
  task automatic plen(input int w, input logic act, output int k);
    k = 0;
    while ((w ? o_horizontal_pin : o_vertical_pin) === act)
      @(negedge i_clock);
    while ((w ? o_horizontal_pin : o_vertical_pin) !== act)
      @(negedge i_clock);
    while ((w ? o_horizontal_pin : o_vertical_pin) === act)
    begin
      k++;
      @(negedge i_clock);
    end
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    seed = 32'd23019;
    {miscompares, total_checks, cycles} = '0;
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
    {i_awaddr, i_araddr, i_wdata} = '0;
    {i_pixel, i_fifo_level, i_genlock_word, run_far} = '0;
    for (i = 0; i < REG_COUNT; i++)
      model[i] = RST_VAL[i];
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    for (i = 0; i < REG_COUNT - 1; i++)
    begin
      axi_rd(8'(i * 4), d, r);
      check("reset value", d, RST_VAL[i]);
    end
    for (i = 0; i < REG_COUNT; i++)
    begin
      wr(i, rnd());
      axi_rd(8'(i * 4), d, r);
      if (i < REG_COUNT - 1)
        check("read back", d, model[i]);
    end
    axi_wr(8'h20, 32'hFFFF_FFFF, r);
    check("unmapped write", 32'(r), 32'(RESP_SLVERR));
    axi_rd(8'hE0, d, r);
    check("unmapped read", d | 32'(r), 32'(RESP_SLVERR));
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      wr(IDX_GPO, rnd());
      repeat (2) @(posedge i_clock);
      check("general outputs", 32'(o_general_outputs), model[5]);
    end
    $display("test general outputs done");
    wr(IDX_TIMING, 32'h000C_0008);
    wr(IDX_HSYNC, 32'h0003_0001);
    wr(IDX_VACT, 32'h0009_0002);
    wr(IDX_HACT, 32'h0006_0001);
    for (i = 0; i < 6; i++)
    begin
      md = (i < 2) ? 0 : (i < 4) ? 3 : 2;
      p = i % 2;
      run_far <= (md == 2);
      wr(IDX_CTRL, 32'(md | p << 2 | p << 3));
      plen(0, !p, n);
      check("vertical span", n, md == 2 ? 224 : 192);
      plen(1, !p, n);
      check("horizontal span", n, md == 2 ? 20 : 16);
    end
    $display("test sync timing done");
    for (p = 0; p < 2; p++)
    begin
      m = rnd() % 32;
      wr(IDX_FIFO, m);
      wr(IDX_CTRL, 32'(2 | p << 4));
      for (j = 0; j < 10; j++)
      begin
        lv = (j == 0) ? m : (j == 1) ? m + 1 : (j == 2) ? 32 - m :
          (j == 3) ? 31 - m : (j == 4) ? 16 : (j == 5) ? 15 : rnd() % 33;
        @(posedge i_clock);
        i_fifo_level <= 6'(lv);
        repeat (4) @(posedge i_clock);
        check("near full", o_fifo_near_full_flag, (lv >= 32 - m) ^ p);
        check("near empty", o_fifo_near_empty_flag, (lv <= m) ^ p);
        check("half flag", o_multi_pin, (lv >= 16) ^ p);
      end
    end
    $display("test fifo flags done");
    wr(IDX_CTRL, 32'h1);
    n = 0;
    b = o_multi_pin;
    repeat (400)
    begin
      @(negedge i_clock);
      n += (o_multi_pin & !b);
      b = o_multi_pin;
    end
    check("qualified clock runs", n > 0, 1);
    run_far <= 1'b0;
    wr(IDX_CTRL, 32'h40);
    @(posedge i_clock);
    i_pixel <= 16'(rnd());
    repeat (12) @(posedge i_clock);
    check("wide pixel bus", o_pixel_bus, i_pixel);
    wr(IDX_CTRL, 32'h0);
    @(posedge i_clock);
    i_pixel <= 16'h5AC3;
    repeat (12) @(posedge i_clock);
    {n, m, j} = '0;
    repeat (16)
    begin
      @(negedge i_clock);
      n += (o_pixel_bus[15:8] === 8'h5A);
      m += (o_pixel_bus[15:8] === 8'hC3);
      j += (o_pixel_bus[7:0] !== 8'h00);
    end
    check("muxed luma slots", n, 8);
    check("muxed chroma slots", m, 8);
    check("muxed lower byte", j, 0);
    {n, m} = '0;
    {a, b} = {o_line_locked_clock, o_half_line_locked_clock};
    repeat (80)
    begin
      @(negedge i_clock);
      n += (o_line_locked_clock & !a);
      m += (o_half_line_locked_clock & !b);
      {a, b} = {o_line_locked_clock, o_half_line_locked_clock};
    end
    check("line-locked rises", n, 20);
    check("half clock rises", m, 10);
    for (i = 0; i < 2; i++)
    begin
      @(posedge i_clock);
      i_genlock_word <= i ? 24'h80_0000 : '1;
      repeat (200) @(posedge i_clock);
      n = 0;
      repeat (96)
      begin
        @(negedge i_clock);
        n += (o_multi_pin === 1'b1);
      end
      check("genlock stream", n, i ? 4 : 96);
    end
    $display("test pins done");
    summarize();
  end
endmodule
